// file: include/idw_pkg.sv
// package for the identify-sector words 50 to 84 generator
`default_nettype none
package idw_pkg;

  // ****************************************
  // bus widths
  // ****************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // ****************************************
  // word indices, address equals word index
  // ****************************************
  localparam logic [7:0] W_STBY = 8'h32;      // word 50
  localparam logic [7:0] W_PIO_LEG = 8'h33;   // word 51
  localparam logic [7:0] W_DMA_LEG = 8'h34;   // word 52
  localparam logic [7:0] W_VALID = 8'h35;     // word 53
  localparam logic [7:0] W_CYL = 8'h36;       // word 54
  localparam logic [7:0] W_HEAD = 8'h37;      // word 55
  localparam logic [7:0] W_SPT = 8'h38;       // word 56
  localparam logic [7:0] W_CAP_LO = 8'h39;    // word 57
  localparam logic [7:0] W_CAP_HI = 8'h3a;    // word 58
  localparam logic [7:0] W_MULT = 8'h3b;      // word 59
  localparam logic [7:0] W_TOT_LO = 8'h3c;    // word 60
  localparam logic [7:0] W_TOT_HI = 8'h3d;    // word 61
  localparam logic [7:0] W_DMA_OLD = 8'h3e;   // word 62
  localparam logic [7:0] W_MDMA = 8'h3f;      // word 63
  localparam logic [7:0] W_PIO_ADV = 8'h40;   // word 64
  localparam logic [7:0] W_MDMA_MIN = 8'h41;  // word 65
  localparam logic [7:0] W_MDMA_REC = 8'h42;  // word 66
  localparam logic [7:0] W_PIO_MIN = 8'h43;   // word 67
  localparam logic [7:0] W_PIO_FC = 8'h44;    // word 68
  localparam logic [7:0] W_QUEUE = 8'h4b;     // word 75
  localparam logic [7:0] W_MAJOR = 8'h50;     // word 80
  localparam logic [7:0] W_MINOR = 8'h51;     // word 81
  localparam logic [7:0] W_CMD1 = 8'h52;      // word 82
  localparam logic [7:0] W_CMD2 = 8'h53;      // word 83
  localparam logic [7:0] W_CMDX = 8'h54;      // word 84
  localparam logic [7:0] W_FIRST = 8'h32;
  localparam logic [7:0] W_LAST = 8'h54;

  // ****************************************
  // field positions and fixed contents
  // ****************************************
  localparam logic [1:0] VALID_TAG = 2'h1;    // 01 in bits 15-14
  localparam int TAG_LSB = 14;
  localparam logic [15:0] PIO_LEG_VAL = 16'h0200;
  localparam logic [15:0] DMA_LEG_VAL = 16'h0200;
  localparam logic [15:0] VALID_VAL = 16'h0007;
  localparam int MULT_VLD_BIT = 8;
  localparam logic [7:0] MDMA_SUPP = 8'h07;
  localparam logic [15:0] PIO_ADV_VAL = 16'h0003;
  localparam int MDMA_MIN_NS = 120;
  localparam int MDMA_REC_NS = 120;
  localparam int PIO_MIN_NS = 240;
  localparam int PIO_FC_NS = 120;
  localparam int QDEPTH_W = 5;
  localparam logic [15:0] MAJOR_VAL = 16'h003c;
  localparam logic [15:0] MINOR_VAL = 16'h0015;
  localparam logic [15:0] CMD1_VAL = 16'h74eb;
  localparam logic [15:0] CMD2_VAL = 16'h43ea;
  localparam logic [15:0] ZERO_W = 16'h0000;

  // ****************************************
  // reset values of the live fields
  // ****************************************
  localparam logic [15:0] RST_CYL = 16'h3fff;
  localparam logic [15:0] RST_HEAD = 16'h0010;
  localparam logic [15:0] RST_SPT = 16'h003f;
  localparam logic [31:0] RST_CAP = 32'h00fb_fc10;
  localparam logic [31:0] RST_TOT = 32'h00fb_fc10;
  localparam logic [7:0] RST_MULT = 8'h10;
  localparam logic RST_MULT_VLD = 1'b0;
  localparam logic [7:0] RST_MDMA_ACT = 8'h00;
  localparam logic [4:0] RST_QDEPTH = 5'h00;
  localparam logic RST_STBY = 1'b0;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } idw_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic valid;
  } idw_rsp_t;

endpackage : idw_pkg
`default_nettype wire

// file: hw/idw_words.sv
// identify-sector words 50 to 84: content generator with live fields
//
// Added by the designer: the address map and the plain strobed port.
`default_nettype none
// Overview of operation
// - identify sector words here sit at fixed word positions, address equals word index
// - word 50 is 01 in 15-14, zero 13-1, bit 0 standby minimum flag
// - word 51 reports fixed legacy PIO timing mode
// - word 52 reports fixed legacy DMA timing mode
// - word 53 sets bits 2-0, bits 15-3 zero
// - words 54-56 give current cylinders, heads, sectors per track
// - words 57-58 give current capacity, low half in 57
// - word 59 multiple count in 7-0, valid in bit 8, 15-9 zero
// - words 60-61 give user-addressable sectors, low half in 60
// - word 63 active multiword DMA mode in 15-8, 07 in 7-0
// - word 64 is 0003, PIO modes 3 and 4
// - word 65 minimum multiword DMA cycle is 120 ns
// - word 66 recommended multiword DMA cycle is 120 ns
// - word 67 minimum PIO cycle without flow control is 240 ns
// - word 68 minimum PIO cycle is 120 ns
// - word 75 queue depth in 4-0, 15-5 zero
// - word 80 major version is 003c
// - word 82 command set supported is 74eb
// - word 83 command set supported is 43ea
// - word 84 is 01 in 15-14, zero 13-8
module idw_words #(
  parameter logic [15:0] RESET_CYL = idw_pkg::RST_CYL,
  parameter logic [15:0] RESET_HEAD = idw_pkg::RST_HEAD,
  parameter logic [15:0] RESET_SPT = idw_pkg::RST_SPT,
  parameter logic [31:0] RESET_CAP = idw_pkg::RST_CAP,
  parameter logic [31:0] RESET_TOT = idw_pkg::RST_TOT
) (
  // clock, reset and clock enable
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // register port
  input wire idw_pkg::idw_req_t req_i,
  output logic [idw_pkg::DATA_W-1:0] rd_data_o,
  output logic rd_valid_o
);
  import idw_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [15:0] cyl;
    logic [15:0] head;
    logic [15:0] spt;
    logic [31:0] cap;
    logic [31:0] tot;
    logic [7:0] mult;
    logic mult_vld;
    logic [7:0] mdma_act;
    logic [QDEPTH_W-1:0] qdepth;
    logic stby;
    idw_rsp_t rsp;
  } idw_state_t;

  idw_state_t st_r;
  idw_state_t st_nxt;

  // ****************************************
  // word content lookup
  // ****************************************
  function automatic logic [15:0] idw_word(input logic [7:0] a, input idw_state_t s);
    logic [15:0] w;
    w = ZERO_W;  // unassigned words in range read zero
    case (a)
      W_STBY: w = {VALID_TAG, 13'h0000, s.stby};
      W_PIO_LEG: w = PIO_LEG_VAL;
      W_DMA_LEG: w = DMA_LEG_VAL;
      W_VALID: w = VALID_VAL;
      W_CYL: w = s.cyl;
      W_HEAD: w = s.head;
      W_SPT: w = s.spt;
      W_CAP_LO: w = s.cap[15:0];
      W_CAP_HI: w = s.cap[31:16];
      W_MULT: w = {7'h00, s.mult_vld, s.mult};
      W_TOT_LO: w = s.tot[15:0];
      W_TOT_HI: w = s.tot[31:16];
      W_DMA_OLD: w = ZERO_W;
      W_MDMA: w = {s.mdma_act, MDMA_SUPP};
      W_PIO_ADV: w = PIO_ADV_VAL;
      W_MDMA_MIN: w = 16'(MDMA_MIN_NS);
      W_MDMA_REC: w = 16'(MDMA_REC_NS);
      W_PIO_MIN: w = 16'(PIO_MIN_NS);
      W_PIO_FC: w = 16'(PIO_FC_NS);
      W_QUEUE: w = {11'h000, s.qdepth};
      W_MAJOR: w = MAJOR_VAL;
      W_MINOR: w = MINOR_VAL;
      W_CMD1: w = CMD1_VAL;
      W_CMD2: w = CMD2_VAL;
      W_CMDX: w = {VALID_TAG, 14'h0000};
      default: w = ZERO_W;
    endcase
    return w;
  endfunction : idw_word

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    // read data stands until the next cycle with ce_i high
    st_nxt.rsp.valid = 1'b0;
    st_nxt.rsp.data = ZERO_W;
    if (req_i.rd) begin
      st_nxt.rsp.valid = 1'b1;
      // outside 50..84 the answer is zero, never a stall
      if (req_i.addr >= W_FIRST && req_i.addr <= W_LAST) begin
        st_nxt.rsp.data = idw_word(req_i.addr, st_r);
      end
    end
    // writes only reach live fields; fixed words ignore them
    if (req_i.wr) begin
      case (req_i.addr)
        W_STBY: st_nxt.stby = req_i.wdata[0];
        W_CYL: st_nxt.cyl = req_i.wdata;
        W_HEAD: st_nxt.head = req_i.wdata;
        W_SPT: st_nxt.spt = req_i.wdata;
        W_CAP_LO: st_nxt.cap[15:0] = req_i.wdata;
        W_CAP_HI: st_nxt.cap[31:16] = req_i.wdata;
        W_MULT: begin
          st_nxt.mult = req_i.wdata[7:0];
          st_nxt.mult_vld = req_i.wdata[MULT_VLD_BIT];
        end
        W_TOT_LO: st_nxt.tot[15:0] = req_i.wdata;
        W_TOT_HI: st_nxt.tot[31:16] = req_i.wdata;
        W_MDMA: st_nxt.mdma_act = req_i.wdata[15:8];
        W_QUEUE: st_nxt.qdepth = req_i.wdata[QDEPTH_W-1:0];
        default: st_nxt.stby = st_nxt.stby;
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      st_r.cyl <= RESET_CYL;
      st_r.head <= RESET_HEAD;
      st_r.spt <= RESET_SPT;
      st_r.cap <= RESET_CAP;
      st_r.tot <= RESET_TOT;
      st_r.mult <= RST_MULT;
      st_r.mult_vld <= RST_MULT_VLD;
      st_r.mdma_act <= RST_MDMA_ACT;
      st_r.qdepth <= RST_QDEPTH;
      st_r.stby <= RST_STBY;
      st_r.rsp <= '0;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  assign rd_data_o = st_r.rsp.data;
  assign rd_valid_o = st_r.rsp.valid;

endmodule : idw_words
`default_nettype wire

// file: bench/idw_words_chk_sva.sv
// checker for the identify words generator
`default_nettype none
module idw_chk (
  // watched ports
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire idw_pkg::idw_req_t req_i,
  input wire logic [idw_pkg::DATA_W-1:0] rd_data_o,
  input wire logic rd_valid_o
);
  import idw_pkg::*;
  // ****
  // read answers
  // ****
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (reset_i);
  sequence rd_at(logic [7:0] a);
    ce_i && req_i.rd && req_i.addr == a;
  endsequence
  a_read_answer: assert property (ce_i && req_i.rd |=> rd_valid_o)
    else $error("read not answered");
  a_idle_quiet: assert property (ce_i && !req_i.rd |=> !rd_valid_o && rd_data_o == 16'h0)
    else $error("answer without read");
  a_word50_tag: assert property (rd_at(W_STBY) |=> rd_data_o[15:1] == 15'h2000)
    else $error("word 50 bad");
  a_valid_flags: assert property (rd_at(W_VALID) |=> rd_data_o == 16'h0007)
    else $error("word 53 bad");
  a_mult_top: assert property (rd_at(W_MULT) |=> rd_data_o[15:9] == 7'h0)
    else $error("word 59 bad");
  a_mdma_supp: assert property (rd_at(W_MDMA) |=> rd_data_o[7:0] == 8'h07)
    else $error("word 63 bad");
  a_queue_top: assert property (rd_at(W_QUEUE) |=> rd_data_o[15:5] == 11'h0)
    else $error("word 75 bad");
  a_cmd_set: assert property (rd_at(W_CMD1) |=> rd_data_o == 16'h74eb)
    else $error("word 82 bad");
  a_cmd_set2: assert property (rd_at(W_CMD2) |=> rd_data_o == 16'h43ea)
    else $error("word 83 bad");
  a_cmd_ext: assert property (rd_at(W_CMDX) |=> rd_data_o[15:8] == 8'h40)
    else $error("word 84 bad");
  a_major_ver: assert property (rd_at(W_MAJOR) |=> rd_data_o == 16'h003c)
    else $error("word 80 bad");
  a_mdma_cycle: assert property (rd_at(W_MDMA_MIN) |=> rd_data_o == 16'h0078)
    else $error("word 65 bad");
  a_word62_zero: assert property (rd_at(W_DMA_OLD) |=> rd_data_o == 16'h0000)
    else $error("word 62 bad");
endmodule : idw_chk
bind idw_words idw_chk chk_u (.clock_i, .reset_i, .ce_i, .req_i, .rd_data_o, .rd_valid_o);
`default_nettype wire

// file: bench/idw_host.sv
// host bus master model for the identify words
`default_nettype none
module idw_host (
  // bus
  input wire logic clock_i,
  output var idw_pkg::idw_req_t req_o,
  input wire logic [idw_pkg::DATA_W-1:0] rd_data_i,
  input wire logic rd_valid_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req_o = '0;
  // idle fields inverted so a stale address never looks valid
  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
                      output logic v, output logic [15:0] q);
    @(posedge clock_i);
    req_o <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge clock_i);
    req_o <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    #1;
    v = rd_valid_i;
    q = rd_data_i;
  endtask : xfer
endmodule : idw_host
`default_nettype wire

// file: bench/tb.sv
// self-checking testbench for the identify words generator
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import idw_pkg::*;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic ce_i = 1'b1;
  idw_req_t req;
  logic [15:0] rd_data;
  logic rd_valid;
  logic v;
  logic [15:0] q;
  logic [15:0] em [0:255];
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  always #2.5 clock_i = ~clock_i;
  idw_host host_u (.clock_i, .req_o(req), .rd_data_i(rd_data), .rd_valid_i(rd_valid));
  idw_words dut_u (.clock_i, .reset_i, .ce_i, .req_i(req), .rd_data_o(rd_data),
                   .rd_valid_o(rd_valid));
  // ****
  // helpers
  // ****
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic final_report();
    if (bad_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report
  task automatic model_reset();
    foreach (em[i]) em[i] = 16'h0;
    em[50] = {15'h2000, RST_STBY};
    em[51] = 16'h0200;
    em[52] = 16'h0200;
    em[53] = 16'h0007;
    em[54] = RST_CYL;
    em[55] = RST_HEAD;
    em[56] = RST_SPT;
    em[57] = RST_CAP[15:0];
    em[58] = RST_CAP[31:16];
    em[59] = {7'h0, RST_MULT_VLD, RST_MULT};
    em[60] = RST_TOT[15:0];
    em[61] = RST_TOT[31:16];
    em[63] = {RST_MDMA_ACT, 8'h07};
    em[64] = 16'h0003;
    em[65] = 16'h0078;
    em[66] = 16'h0078;
    em[67] = 16'h00f0;
    em[68] = 16'h0078;
    em[75] = {11'h0, RST_QDEPTH};
    em[80] = 16'h003c;
    em[81] = 16'h0015;
    em[82] = 16'h74eb;
    em[83] = 16'h43ea;
    em[84] = 16'h4000;
  endtask : model_reset
  // fixed and unmapped words keep the model untouched
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    host_u.xfer(1'b1, a, d, v, q);
    case (a)
      8'd50: em[50][0] = d[0];
      8'd54, 8'd55, 8'd56, 8'd57, 8'd58, 8'd60, 8'd61: em[a] = d;
      8'd59: em[59][8:0] = d[8:0];
      8'd63: em[63][15:8] = d[15:8];
      8'd75: em[75][4:0] = d[4:0];
      default: ;
    endcase
    chk("write answer", 16'h0, {15'h0, v});
  endtask : wr
  task automatic check_all();
    for (int a = 'h30; a < 'h57; a++) begin
      string nm;
      nm = $sformatf("word %0d", a);
      host_u.xfer(1'b0, 8'(a), 16'h0, v, q);
      chk("read valid", 16'h1, {15'h0, v});
      if (a < 'h36) chk(nm, em[a], q);
      else if (a < 'h3e) chk(nm, em[a], q);
      else if (a < 'h45) chk(nm, em[a], q);
      else chk(nm, em[a], q);
    end
  endtask : check_all
  // ****
  // scenarios
  // ****
  task automatic sc_writes(input logic [15:0] p);
    for (int a = 'h30; a < 'h57; a++) wr(8'(a), p ^ 16'(a * 'h0101));
    check_all();
  endtask : sc_writes
  task automatic sc_ce_freeze();
    @(posedge clock_i);
    ce_i <= 1'b0;
    host_u.xfer(1'b0, W_VALID, 16'h0, v, q);
    chk("frozen valid", 16'h0, {15'h0, v});
    host_u.xfer(1'b1, W_CYL, 16'hdead, v, q);
    @(posedge clock_i);
    ce_i <= 1'b1;
    check_all();
  endtask : sc_ce_freeze
  task automatic sc_mid_reset();
    @(posedge clock_i);
    reset_i <= 1'b1;
    ce_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    reset_i <= 1'b0;
    ce_i <= 1'b1;
    model_reset();
    check_all();
  endtask : sc_mid_reset
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      final_report();
    end
  end
  initial begin
    repeat (20) @(posedge clock_i);
    reset_i <= 1'b0;
    model_reset();
    check_all();
    sc_writes(16'ha5c3);
    sc_writes(16'h5a3c);
    sc_ce_freeze();
    sc_mid_reset();
    final_report();
  end
endmodule : tb
`default_nettype wire
